// File: adc_cfg_pkg.sv
// Shared offsets, field layouts, reset values and encodings for the converter configuration block
package adc_cfg_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_SAMPLE_TIME_CHANNELS_LOW       = 8'h10;
    localparam logic [7:0] OFS_WATCHDOG_UPPER_LIMIT           = 8'h24;
    localparam logic [7:0] OFS_WATCHDOG_LOWER_LIMIT           = 8'h28;
    localparam logic [7:0] OFS_SEQUENCE_LENGTH_AND_LAST_SLOTS = 8'h2C;
    localparam logic [7:0] OFS_SEQUENCE_MIDDLE_SLOTS          = 8'h30;

    // Reset values
    localparam logic [31:0] RST_SAMPLE_TIME_CHANNELS_LOW       = 32'h0000_0000;
    localparam logic [31:0] RST_WATCHDOG_UPPER_LIMIT           = 32'h0000_0FFF;
    localparam logic [31:0] RST_WATCHDOG_LOWER_LIMIT           = 32'h0000_0000;
    localparam logic [31:0] RST_SEQUENCE_LENGTH_AND_LAST_SLOTS = 32'h0000_0000;
    localparam logic [31:0] RST_SEQUENCE_MIDDLE_SLOTS          = 32'h0000_0000;

    // Writable bits of each register; everything else is reserved and reads zero
    localparam logic [31:0] MASK_SAMPLE_TIME       = 32'h3FFF_FFFF;
    localparam logic [31:0] MASK_WATCHDOG_LIMIT    = 32'h0000_0FFF;
    localparam logic [31:0] MASK_LENGTH_LAST_SLOTS = 32'h00FF_FFFF;
    localparam logic [31:0] MASK_MIDDLE_SLOTS      = 32'h3FFF_FFFF;

    // Field layout
    localparam int SAMPLE_SEL_WIDTH   = 3;
    localparam int LOW_SAMPLE_CHANS   = 10;
    localparam int HIGH_SAMPLE_CHANS  = 8;
    localparam int NUM_CHANNELS       = 18;
    localparam int SLOT_WIDTH         = 5;
    localparam int NUM_SLOTS          = 16;
    localparam int LOW_SLOTS          = 6;
    localparam int MIDDLE_SLOTS       = 6;
    localparam int LAST_SLOTS         = 4;
    localparam int LIMIT_WIDTH        = 12;
    localparam int SEQ_LEN_LSB        = 20;
    localparam int SEQ_LEN_WIDTH      = 4;
    localparam logic [4:0] MAX_CHANNEL = 5'h11;

    // Sampling duration in half converter-clock cycles, indexed by selector code
    localparam int HALF_CYCLE_WIDTH = 10;
    localparam logic [9:0] SAMPLE_HALF_CYCLES [8] = '{
        10'h003, 10'h00F, 10'h01B, 10'h039, 10'h053, 10'h06F, 10'h08F, 10'h1DF
    };

endpackage

// File: adc_slot_sequencer.sv
// Walks the conversion slots in order and hands each channel to the converter core
`timescale 1ns/100ps
module adc_slot_sequencer
    import adc_cfg_pkg::*;
(
    // Clock and synchronised reset
    input  wire logic                                       clk,
    input  wire logic                                       rst_n,
    // Configuration
    input  wire logic [NUM_SLOTS*SLOT_WIDTH-1:0]            slot_channels,
    input  wire logic [NUM_CHANNELS*SAMPLE_SEL_WIDTH-1:0]   chan_sample_sel,
    input  wire logic [SEQ_LEN_WIDTH-1:0]                   seq_len_minus_one,
    // Converter core handshake
    input  wire logic                                       seq_start,
    input  wire logic                                       conv_done,
    output logic                                            conv_req,
    output logic [SLOT_WIDTH-1:0]                           conv_channel,
    output logic [SAMPLE_SEL_WIDTH-1:0]                     conv_sample_sel,
    output logic [HALF_CYCLE_WIDTH-1:0]                     conv_sample_half_cycles,
    output logic                                            seq_busy,
    output logic                                            seq_end
);
    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} seq_state_e;

    seq_state_e                  state_reg, state_next;
    logic [3:0]                  slot_reg, slot_next;
    logic                        req_reg, req_next;
    logic                        end_reg, end_next;
    logic [SLOT_WIDTH-1:0]       chan_reg, chan_next;
    logic [SAMPLE_SEL_WIDTH-1:0] sel_reg, sel_next;
    logic [HALF_CYCLE_WIDTH-1:0] half_reg, half_next;
    logic                        busy_reg, busy_next;
    logic [SLOT_WIDTH-1:0]       cur_chan;
    logic [SAMPLE_SEL_WIDTH-1:0] cur_sel;
    logic                        last_slot;

    assign cur_chan  = slot_channels[slot_reg*SLOT_WIDTH +: SLOT_WIDTH];
    assign last_slot = (slot_reg == seq_len_minus_one);

    always_comb
    begin
        cur_sel = '0;
        if (cur_chan <= MAX_CHANNEL)
        begin
            cur_sel = chan_sample_sel[cur_chan*SAMPLE_SEL_WIDTH +: SAMPLE_SEL_WIDTH];
        end
    end

    always_comb
    begin
        state_next = state_reg;
        slot_next  = slot_reg;
        req_next   = 1'b0;
        end_next   = 1'b0;
        chan_next  = chan_reg;
        sel_next   = sel_reg;
        half_next  = half_reg;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (seq_start)
                begin
                    slot_next  = '0;
                    state_next = ST_ISSUE;
                end
            end
            ST_ISSUE:
            begin
                // A slot naming no existing channel is skipped rather than stalling the sequence
                if (cur_chan <= MAX_CHANNEL)
                begin
                    req_next   = 1'b1;
                    chan_next  = cur_chan;
                    sel_next   = cur_sel;
                    // Decoded here so the duration leaves a flop together with its selector
                    half_next  = SAMPLE_HALF_CYCLES[cur_sel];
                    state_next = ST_WAIT;
                end
                else if (last_slot)
                begin
                    end_next   = 1'b1;
                    state_next = ST_IDLE;
                end
                else
                begin
                    slot_next = slot_reg + 4'h1;
                end
            end
            ST_WAIT:
            begin
                if (conv_done)
                begin
                    if (last_slot)
                    begin
                        end_next   = 1'b1;
                        state_next = ST_IDLE;
                    end
                    else
                    begin
                        slot_next  = slot_reg + 4'h1;
                        state_next = ST_ISSUE;
                    end
                end
            end
        endcase
        busy_next = (state_next != ST_IDLE);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            slot_reg  <= '0;
            req_reg   <= 1'b0;
            end_reg   <= 1'b0;
            chan_reg  <= '0;
            sel_reg   <= '0;
            half_reg  <= '0;
            busy_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            slot_reg  <= slot_next;
            req_reg   <= req_next;
            end_reg   <= end_next;
            chan_reg  <= chan_next;
            sel_reg   <= sel_next;
            half_reg  <= half_next;
            busy_reg  <= busy_next;
        end
    end

    assign conv_req                = req_reg;
    assign conv_channel            = chan_reg;
    assign conv_sample_sel         = sel_reg;
    assign conv_sample_half_cycles = half_reg;
    assign seq_busy                = busy_reg;
    assign seq_end                 = end_reg;
endmodule

// File: adc_sample_seq_watchdog_cfg.sv
// Sample-time, watchdog-limit and routine-sequence configuration registers of the converter
//
// Function
// - Three-bit sample selector per channel 0-9
// - Upper watchdog limit, 12 bits, resets all ones
// - Lower watchdog limit, 12 bits, resets zero
// - Length field plus one gives the number of slots walked
// - Slots 6-15 are 5-bit read-write fields
// - Slot field holds a 5-bit value 0-31; channels 0-17 are converted, 18-31 are skipped
`timescale 1ns/100ps
module adc_sample_seq_watchdog_cfg
    import adc_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic                                               clk,
    input  wire logic                                               resetn,
    // Register access port
    input  wire logic [7:0]                                         reg_addr,
    input  wire logic                                               reg_wr,
    input  wire logic                                               reg_rd,
    input  wire logic                                               reg_word,
    input  wire logic [31:0]                                        reg_wdata,
    output logic [31:0]                                             reg_rdata,
    output logic                                                    reg_ack,
    output logic                                                    reg_err,
    // Configuration held outside this block
    input  wire logic [adc_cfg_pkg::LOW_SLOTS*adc_cfg_pkg::SLOT_WIDTH-1:0]               slot_low_channels,
    input  wire logic [adc_cfg_pkg::HIGH_SAMPLE_CHANS*adc_cfg_pkg::SAMPLE_SEL_WIDTH-1:0] high_sample_sel,
    // Configuration to the converter core
    output logic [adc_cfg_pkg::LOW_SAMPLE_CHANS*adc_cfg_pkg::SAMPLE_SEL_WIDTH-1:0]       chan_sample_sel,
    output logic [adc_cfg_pkg::LIMIT_WIDTH-1:0]                     watchdog_upper_limit_field,
    output logic [adc_cfg_pkg::LIMIT_WIDTH-1:0]                     watchdog_lower_limit_field,
    output logic [adc_cfg_pkg::SEQ_LEN_WIDTH-1:0]                   sequence_count_minus_one,
    // Conversion sequencing
    input  wire logic                                               seq_start,
    input  wire logic                                               conv_done,
    output logic                                                    conv_req,
    output logic [adc_cfg_pkg::SLOT_WIDTH-1:0]                      conv_channel,
    output logic [adc_cfg_pkg::SAMPLE_SEL_WIDTH-1:0]                conv_sample_sel,
    output logic [adc_cfg_pkg::HALF_CYCLE_WIDTH-1:0]                conv_sample_half_cycles,
    output logic                                                    seq_busy,
    output logic                                                    seq_end
);
    import adc_cfg_pkg::*;

    // Reset release synchroniser; assertion stays asynchronous
    logic        rst_meta_reg;
    logic        rst_sync_reg;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Register state
    logic [31:0] sample_time_channels_low_reg,       sample_time_channels_low_next;
    logic [31:0] watchdog_upper_limit_reg,           watchdog_upper_limit_next;
    logic [31:0] watchdog_lower_limit_reg,           watchdog_lower_limit_next;
    logic [31:0] sequence_length_and_last_slots_reg, sequence_length_and_last_slots_next;
    logic [31:0] sequence_middle_slots_reg,          sequence_middle_slots_next;
    logic [31:0] rdata_reg,                          rdata_next;
    logic        ack_reg,                            ack_next;
    logic        err_reg,                            err_next;

    // Address decode
    logic        hit_sample;
    logic        hit_upper;
    logic        hit_lower;
    logic        hit_last;
    logic        hit_middle;
    logic        wr_ok;

    assign hit_sample = (reg_addr == OFS_SAMPLE_TIME_CHANNELS_LOW);
    assign hit_upper  = (reg_addr == OFS_WATCHDOG_UPPER_LIMIT);
    assign hit_lower  = (reg_addr == OFS_WATCHDOG_LOWER_LIMIT);
    assign hit_last   = (reg_addr == OFS_SEQUENCE_LENGTH_AND_LAST_SLOTS);
    assign hit_middle = (reg_addr == OFS_SEQUENCE_MIDDLE_SLOTS);

    // Narrow writes are dropped whole: a partial lane merge would corrupt neighbouring fields
    assign wr_ok = reg_wr && reg_word;

    always_comb
    begin
        sample_time_channels_low_next       = sample_time_channels_low_reg;
        watchdog_upper_limit_next           = watchdog_upper_limit_reg;
        watchdog_lower_limit_next           = watchdog_lower_limit_reg;
        sequence_length_and_last_slots_next = sequence_length_and_last_slots_reg;
        sequence_middle_slots_next          = sequence_middle_slots_reg;
        if (wr_ok && hit_sample)
        begin
            sample_time_channels_low_next = reg_wdata & MASK_SAMPLE_TIME;
        end
        if (wr_ok && hit_upper)
        begin
            watchdog_upper_limit_next = reg_wdata & MASK_WATCHDOG_LIMIT;
        end
        if (wr_ok && hit_lower)
        begin
            watchdog_lower_limit_next = reg_wdata & MASK_WATCHDOG_LIMIT;
        end
        if (wr_ok && hit_last)
        begin
            sequence_length_and_last_slots_next = reg_wdata & MASK_LENGTH_LAST_SLOTS;
        end
        if (wr_ok && hit_middle)
        begin
            sequence_middle_slots_next = reg_wdata & MASK_MIDDLE_SLOTS;
        end
    end

    // Read path; reserved bits are never stored so they read back as zero
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        ack_next   = reg_wr || reg_rd;
        err_next   = (reg_wr || reg_rd) && !reg_word;
        if (reg_rd && reg_word)
        begin
            unique case (1'b1)
                hit_sample: rdata_next = sample_time_channels_low_reg;
                hit_upper:  rdata_next = watchdog_upper_limit_reg;
                hit_lower:  rdata_next = watchdog_lower_limit_reg;
                hit_last:   rdata_next = sequence_length_and_last_slots_reg;
                hit_middle: rdata_next = sequence_middle_slots_reg;
                default:    rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            sample_time_channels_low_reg       <= RST_SAMPLE_TIME_CHANNELS_LOW;
            watchdog_upper_limit_reg           <= RST_WATCHDOG_UPPER_LIMIT;
            watchdog_lower_limit_reg           <= RST_WATCHDOG_LOWER_LIMIT;
            sequence_length_and_last_slots_reg <= RST_SEQUENCE_LENGTH_AND_LAST_SLOTS;
            sequence_middle_slots_reg          <= RST_SEQUENCE_MIDDLE_SLOTS;
            rdata_reg                          <= 32'h0000_0000;
            ack_reg                            <= 1'b0;
            err_reg                            <= 1'b0;
        end
        else
        begin
            sample_time_channels_low_reg       <= sample_time_channels_low_next;
            watchdog_upper_limit_reg           <= watchdog_upper_limit_next;
            watchdog_lower_limit_reg           <= watchdog_lower_limit_next;
            sequence_length_and_last_slots_reg <= sequence_length_and_last_slots_next;
            sequence_middle_slots_reg          <= sequence_middle_slots_next;
            rdata_reg                          <= rdata_next;
            ack_reg                            <= ack_next;
            err_reg                            <= err_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_ack   = ack_reg;
    assign reg_err   = err_reg;

    // Field views for the converter core, straight from the register flops
    assign chan_sample_sel            = sample_time_channels_low_reg[LOW_SAMPLE_CHANS*SAMPLE_SEL_WIDTH-1:0];
    assign watchdog_upper_limit_field = watchdog_upper_limit_reg[LIMIT_WIDTH-1:0];
    assign watchdog_lower_limit_field = watchdog_lower_limit_reg[LIMIT_WIDTH-1:0];
    assign sequence_count_minus_one   = sequence_length_and_last_slots_reg[SEQ_LEN_LSB +: SEQ_LEN_WIDTH];

    // Full slot and sample-time tables, lowest slot and channel in the low bits
    logic [NUM_SLOTS*SLOT_WIDTH-1:0]          all_slots;
    logic [NUM_CHANNELS*SAMPLE_SEL_WIDTH-1:0] all_sample_sel;

    assign all_slots = {
        sequence_length_and_last_slots_reg[LAST_SLOTS*SLOT_WIDTH-1:0],
        sequence_middle_slots_reg[MIDDLE_SLOTS*SLOT_WIDTH-1:0],
        slot_low_channels
    };
    assign all_sample_sel = {high_sample_sel, sample_time_channels_low_reg[LOW_SAMPLE_CHANS*SAMPLE_SEL_WIDTH-1:0]};

    // Settings are read live at each slot, so a write during a sequence affects later slots only
    adc_slot_sequencer u_sequencer
    (
        .clk                     (clk),
        .rst_n                   (rst_sync_reg),
        .slot_channels           (all_slots),
        .chan_sample_sel         (all_sample_sel),
        .seq_len_minus_one       (sequence_count_minus_one),
        .seq_start               (seq_start),
        .conv_done               (conv_done),
        .conv_req                (conv_req),
        .conv_channel            (conv_channel),
        .conv_sample_sel         (conv_sample_sel),
        .conv_sample_half_cycles (conv_sample_half_cycles),
        .seq_busy                (seq_busy),
        .seq_end                 (seq_end)
    );
endmodule

// File: adc_cfg_monitor.sv
// Concurrent checks on the ports of the converter configuration block
`timescale 1ns/100ps
module adc_cfg_monitor
    import adc_cfg_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        reg_word,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_ack,
    input wire logic        reg_err,
    // Configuration outputs
    input wire logic [29:0] chan_sample_sel,
    input wire logic [11:0] watchdog_upper_limit_field,
    input wire logic [11:0] watchdog_lower_limit_field,
    input wire logic [3:0]  sequence_count_minus_one,
    // Sequencing
    input wire logic        seq_start,
    input wire logic        conv_req,
    input wire logic [4:0]  conv_channel,
    input wire logic [2:0]  conv_sample_sel,
    input wire logic [9:0]  conv_sample_half_cycles,
    input wire logic        seq_busy,
    input wire logic        seq_end
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_req; reg_wr || reg_rd; endsequence
    sequence s_wr(a); reg_wr && reg_word && reg_addr == a; endsequence
    sequence s_open; seq_start && !seq_busy; endsequence

    property p_ack; s_req |=> reg_ack && reg_err == !$past(reg_word); endproperty
    a_ack: assert property (p_ack) else $error("ack or err missing after request");
    property p_ack_cause; reg_ack |-> $past(reg_wr || reg_rd); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_upper; s_wr(OFS_WATCHDOG_UPPER_LIMIT) |=> watchdog_upper_limit_field == $past(reg_wdata[11:0]); endproperty
    a_upper: assert property (p_upper) else $error("upper limit not taken");
    property p_lower; s_wr(OFS_WATCHDOG_LOWER_LIMIT) |=> watchdog_lower_limit_field == $past(reg_wdata[11:0]); endproperty
    a_lower: assert property (p_lower) else $error("lower limit not taken");
    property p_len; s_wr(OFS_SEQUENCE_LENGTH_AND_LAST_SLOTS) |=> sequence_count_minus_one == $past(reg_wdata[23:20]);
    endproperty
    a_len: assert property (p_len) else $error("length field not taken");
    property p_samp; s_wr(OFS_SAMPLE_TIME_CHANNELS_LOW) |=> chan_sample_sel == $past(reg_wdata[29:0]); endproperty
    a_samp: assert property (p_samp) else $error("sample selectors not taken");
    property p_rsv; reg_rd && reg_addr == OFS_SAMPLE_TIME_CHANNELS_LOW |=> reg_rdata[31:30] == 2'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
    property p_half; conv_req |-> conv_sample_half_cycles == SAMPLE_HALF_CYCLES[conv_sample_sel]; endproperty
    a_half: assert property (p_half) else $error("sample duration mismatch");
    property p_chan; conv_req |-> conv_channel <= MAX_CHANNEL; endproperty
    a_chan: assert property (p_chan) else $error("channel out of range requested");
    property p_start; s_open |=> seq_busy; endproperty
    a_start: assert property (p_start) else $error("sequence did not start");
    property p_end; seq_end |-> !seq_busy ##1 !seq_end; endproperty
    a_end: assert property (p_end) else $error("sequence end malformed");
endmodule

bind adc_sample_seq_watchdog_cfg adc_cfg_monitor mon (.*);

// File: conv_core_model.sv
// Behavioural converter core answering each conversion request after a delay
`timescale 1ns/100ps
module conv_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Sequencer handshake
    input wire logic conv_req,
    input wire logic slow,
    output logic     conv_done
);
    int cnt;
    // Slow mode keeps the sequencer waiting several cycles per conversion
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt <= 0;
            conv_done <= 1'b0;
        end
        else
        begin
            conv_done <= (cnt == 1);
            if (conv_req)
                cnt <= slow ? 9 : 2;
            else if (cnt > 0)
                cnt <= cnt - 1;
        end
    end
endmodule

// File: testbench.sv
// Self-checking bench for the converter configuration block
`timescale 1ns/100ps
module testbench;
    import adc_cfg_pkg::*;
    logic        clk;
    logic        resetn;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic        reg_word;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        reg_ack;
    logic        reg_err;
    logic [29:0] slot_low_channels;
    logic [23:0] high_sample_sel;
    logic [29:0] chan_sample_sel;
    logic [11:0] upper;
    logic [11:0] lower;
    logic [3:0]  len_m1;
    logic        seq_start;
    logic        conv_done;
    logic        conv_req;
    logic [4:0]  conv_channel;
    logic [2:0]  conv_sample_sel;
    logic [9:0]  conv_half;
    logic        seq_busy;
    logic        seq_end;
    logic        slow;
    int          errors;
    int          checked;
    int          ends;
    logic [31:0] shadow [5];
    logic [17:0] seen_q [$];
    logic [17:0] exp_q [$];
    localparam logic [7:0]  OFS [5] = '{8'h10, 8'h24, 8'h28, 8'h2C, 8'h30};
    localparam logic [31:0] MSK [5] = '{32'h3FFF_FFFF, 32'hFFF, 32'hFFF, 32'hFF_FFFF, 32'h3FFF_FFFF};
    localparam logic [31:0] RST [5] = '{32'h0, 32'hFFF, 32'h0, 32'h0, 32'h0};
    // Twice the sampling time in converter cycles, per selector code
    localparam logic [9:0]  HALF [8] = '{10'h003, 10'h00F, 10'h01B, 10'h039, 10'h053, 10'h06F, 10'h08F, 10'h1DF};

    adc_sample_seq_watchdog_cfg uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_word(reg_word), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_err(reg_err), .slot_low_channels(slot_low_channels), .high_sample_sel(high_sample_sel),
        .chan_sample_sel(chan_sample_sel), .watchdog_upper_limit_field(upper), .watchdog_lower_limit_field(lower),
        .sequence_count_minus_one(len_m1), .seq_start(seq_start), .conv_done(conv_done), .conv_req(conv_req),
        .conv_channel(conv_channel), .conv_sample_sel(conv_sample_sel), .conv_sample_half_cycles(conv_half),
        .seq_busy(seq_busy), .seq_end(seq_end));
    conv_core_model core (.clk(clk), .resetn(resetn), .conv_req(conv_req), .slow(slow), .conv_done(conv_done));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (conv_req === 1'b1)
            seen_q.push_back({conv_half, conv_sample_sel, conv_channel});
        if (seq_end === 1'b1)
            ends++;
    end

    function automatic logic [31:0] rnd_slots(int n);
        logic [31:0] r;
        r = 32'h0;
        // Values 18 and 19 exercise the skipping of invalid channels
        for (int k = 0; k < n; k++)
            r[5*k +: 5] = 5'($urandom % 20);
        return r;
    endfunction

    function automatic logic [4:0] slot_ch(int s);
        if (s < 6)
            return slot_low_channels[5*s +: 5];
        if (s < 12)
            return shadow[4][5*(s-6) +: 5];
        return shadow[3][5*(s-12) +: 5];
    endfunction

    function automatic logic [2:0] sel_of(logic [4:0] ch);
        if (ch < 10)
            return shadow[0][3*ch +: 3];
        return high_sample_sel[3*(ch-10) +: 3];
    endfunction

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One access; an idle cycle follows so strobes never toggle twice in a step
    task automatic acc(logic wr, logic [7:0] a, logic [31:0] d, logic w, output logic [31:0] q);
        reg_addr = a;
        reg_wdata = d;
        reg_word = w;
        reg_wr = wr;
        reg_rd = !wr;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        chk("ack", reg_ack, 32'h1);
        chk("err", reg_err, !w);
        q = reg_rdata;
        @(posedge clk);
        #1;
    endtask

    task automatic run_seq(logic s);
        logic [4:0] ch;
        int e0;
        seen_q.delete();
        exp_q.delete();
        for (int k = 0; k <= shadow[3][23:20]; k++)
        begin
            ch = slot_ch(k);
            if (ch <= 5'h11)
                exp_q.push_back({HALF[sel_of(ch)], sel_of(ch), ch});
        end
        slow = s;
        e0 = ends;
        seq_start = 1'b1;
        @(posedge clk);
        #1;
        seq_start = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        if (seq_busy === 1'b1)
        begin
            seq_start = 1'b1;
            @(posedge clk);
            #1;
            seq_start = 1'b0;
        end
        for (int n = 0; n < 3000 && ends == e0; n++)
        begin
            @(posedge clk);
            #1;
        end
        repeat (4) @(posedge clk);
        #1;
        chk("seq ends", ends, e0 + 1);
        chk("busy after end", seq_busy, 32'h0);
        chk("conv count", seen_q.size(), exp_q.size());
        foreach (exp_q[i])
            if (i < seen_q.size())
                chk("conv", seen_q[i], exp_q[i]);
    endtask

    task final_report;
        if (errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #1000000;
        errors++;
        final_report();
    end

    initial
    begin
        logic [31:0] q;
        logic [31:0] d;
        {resetn, reg_wr, reg_rd, reg_word, seq_start, slow} = 6'h00;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        slot_low_channels = 30'h0;
        high_sample_sel = 24'h0;
        errors = 0;
        checked = 0;
        ends = 0;
        void'($urandom(51091));
        repeat (4) @(posedge clk);
        #1;
        resetn = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("upper out", upper, 32'hFFF);
        for (int i = 0; i < 5; i++)
        begin
            acc(1'b0, OFS[i], 32'h0, 1'b1, q);
            chk("reset value", q, RST[i]);
            shadow[i] = RST[i];
        end
        acc(1'b1, OFS[1], 32'h0000_05A5, 1'b0, q);
        acc(1'b0, OFS[1], 32'h0, 1'b0, q);
        chk("narrow read", q, 32'h0);
        acc(1'b0, OFS[1], 32'h0, 1'b1, q);
        chk("after narrow write", q, 32'h0000_0FFF);
        acc(1'b0, 8'h14, 32'h0, 1'b1, q);
        chk("unmapped read", q, 32'h0);
        for (int it = 0; it < 12; it++)
        begin
            d = rnd_slots(6);
            slot_low_channels = d[29:0];
            if (it < 8)
                slot_low_channels[4:0] = 5'h00;
            high_sample_sel = 24'($urandom);
            for (int i = 0; i < 5; i++)
            begin
                d = (i == 3) ? rnd_slots(4) : (i == 4) ? rnd_slots(6) : $urandom;
                if (i == 0 && it < 8)
                    d[2:0] = 3'(it);
                if (i == 3)
                    d[23:20] = it < 8 ? 4'h0 : it == 11 ? 4'hF : 4'($urandom);
                d = d & MSK[i];
                acc(1'b1, OFS[i], d, 1'b1, q);
                shadow[i] = d;
            end
            for (int i = 0; i < 5; i++)
            begin
                acc(1'b0, OFS[i], 32'h0, 1'b1, q);
                chk("read back", q, shadow[i]);
            end
            chk("sample sel out", chan_sample_sel, shadow[0][29:0]);
            chk("upper out", upper, shadow[1][11:0]);
            chk("lower out", lower, shadow[2][11:0]);
            chk("length out", len_m1, shadow[3][23:20]);
            run_seq(it[0]);
        end
        final_report();
    end
endmodule
